// ### rtl/pms_defines.svh
// Constants for the dual-port serial register slave: page codes, bus
// addresses, internal register indices, reset values and timing figures.
// Assumes inclusion by bare name from the design files that need them.
`ifndef PMS_DEFINES_SVH
`define PMS_DEFINES_SVH

// ==========================================================================
// Page codes presented on the register access ports
// ==========================================================================
`define PMS_PAGE_POWER      3'h0
`define PMS_PAGE_IFACE      3'h1
`define PMS_PAGE_TRIM       3'h2
`define PMS_PAGE_OTP        3'h3
`define PMS_PAGE_SCALING    3'h4

// ==========================================================================
// Bus addresses (seven bits)
// ==========================================================================
// Upper five bits of the default and alternative general pages.
`define PMS_GEN_BASE_DEF    5'h12
`define PMS_GEN_BASE_ALT    5'h16
`define PMS_SCALING_ADDR    7'h12
`define PMS_HS_CODE_TOP     5'h01
`define PMS_GENERAL_CALL    7'h00

// ==========================================================================
// Internal registers, reached through the interfaces page
// ==========================================================================
`define PMS_REMAP_IDX       8'hf0
`define PMS_STATUS_IDX      8'hf1
`define PMS_REMAP_RESET     8'h00
`define PMS_UNDEF_VALUE     8'hff
`define PMS_BYTE_BITS       4'h8

// ==========================================================================
// Timing
// ==========================================================================
`define PMS_STD_RATE_KBPS   100
`define PMS_FAST_RATE_KBPS  400
`define PMS_HS_RATE_KBPS    3400
// Edge detection needs this many clock cycles per half bit period.
`define PMS_MIN_HALF_CYCLES 8

`endif

// ### rtl/pms_pkg.sv
// Types shared by the dual-port serial register slave.
// Assumes the defines header is compiled alongside.
package pms_pkg;

    // ======================================================================
    // Serial engine states
    // ======================================================================
    typedef enum logic [2:0] {
        PMS_IDLE     = 3'b000,
        PMS_ADDR     = 3'b001,
        PMS_ADDR_ACK = 3'b010,
        PMS_WR       = 3'b011,
        PMS_WR_ACK   = 3'b100,
        PMS_RD       = 3'b101,
        PMS_RD_ACK   = 3'b110
    } pms_state_t;

    typedef struct packed {
        pms_state_t  state;
        logic [3:0]  bitCnt;
        logic [7:0]  shift;
        logic [7:0]  tx;
        logic        rw;
        logic [2:0]  page;
        logic [7:0]  idx;
        logic        idxLoaded;
        logic        hsMode;
        logic        drvLow;
        logic        nack;
        logic        sclPrev;
        logic        sdaPrev;
        logic        wrPulse;
        logic [7:0]  wdata;
    } pms_port_t;

    typedef struct packed {
        pms_port_t [1:0] port;
        logic [7:0]      remap;
    } pms_top_t;

    typedef struct packed {
        logic [1:0] stage1;
        logic [1:0] stage2;
        logic [1:0] stage3;
        logic [1:0] filt;
    } pms_sync_t;

endpackage : pms_pkg

// ### rtl/pms_line_if.sv
// Filtered clock and data levels of one serial port.
// Assumes one synchroniser drives it and the engine only reads it.
`timescale 1ns/1ps
interface pms_line_if;
    logic scl;
    logic sda;
    modport src (output scl, output sda);
    modport dst (input scl, input sda);
endinterface : pms_line_if

// ### rtl/pms_pin_sync.sv
// Three-stage synchroniser and agreement filter for one clock and data pin.
// Assumes pins are asynchronous to clk and idle high.
`timescale 1ns/1ps
`include "pms_defines.svh"
module pms_pin_sync (
    input  wire logic  clk,
    input  wire logic  srst,
    input  wire logic  ce,
    input  wire logic  sclPin,
    input  wire logic  sdaPin,
    pms_line_if.src    line
);
    pms_pkg::pms_sync_t st;
    pms_pkg::pms_sync_t next_st;

    // ======================================================================
    // Filter
    // ======================================================================
    // A level is accepted only when stages two and three agree, which rejects
    // single-cycle glitches at the cost of one cycle of latency after stage three.
    always_comb begin
        next_st        = st;
        next_st.stage1 = {sclPin, sdaPin};
        next_st.stage2 = st.stage1;
        next_st.stage3 = st.stage2;
        for (int b = 0; b < 2; b++) begin
            if (st.stage2[b] == st.stage3[b]) begin
                next_st.filt[b] = st.stage3[b];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '{stage1: 2'h3, stage2: 2'h3, stage3: 2'h3, filt: 2'h3};
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign line.scl = st.filt[1];
    assign line.sda = st.filt[0];

endmodule : pms_pin_sync

// ### rtl/pms_dual_slave.sv
// Two serial register slave ports: the general port with four remappable
// page addresses and the scaling port at one fixed address.
// Assumes the register space answers combinationally to page and index.
//
// How it works
// - Slave only: never drives the clock, never arbitrates.
// - Works at 100 kbps, 400 kbps and 3.4 Mbps bus rates.
// - Seven-bit addresses only; no ten-bit, general call ignored.
// - General port answers 010010xx; low two bits select the page.
// - Pages of 256: power, interfaces, trimming, OTP, scaling.
// - Scaling port answers only address 0x12.
// - Both ports run independently without interfering.
// - Select bits 0 to 3 move pages to 0x58 through 0x5B.
// - Scaling port address is never remapped.
// - Data falling while clock high starts an address byte.
// - Acknowledge address only on a match, low through ninth clock.
// - Eight data bits plus acknowledge by the receiver, repeating.
// - Data rising while clock high ends the link and releases.
// - Undefined registers read as 0xFF.
// - High-speed master code is recognised, not acknowledged.
// - High-speed mode holds over repeated starts, ends on stop.
// - Scaling port reaches only the scaling page.
`timescale 1ns/1ps
`include "pms_defines.svh"
module pms_dual_slave #(
    parameter int CLK_KHZ = 100000
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        primaryClockPin,
    input  wire logic        primaryDataPin,
    output logic             primaryDataOut,
    output logic             primaryDataOeN,
    input  wire logic        scalingClockPin,
    input  wire logic        scalingDataPin,
    output logic             scalingDataOut,
    output logic             scalingDataOeN,
    output logic [2:0]       primaryRegPage,
    output logic [7:0]       primaryRegIndex,
    output logic [7:0]       primaryRegWdata,
    output logic             primaryRegWrite,
    input  wire logic [7:0]  primaryRegRdata,
    input  wire logic        primaryRegDefined,
    output logic [2:0]       scalingRegPage,
    output logic [7:0]       scalingRegIndex,
    output logic [7:0]       scalingRegWdata,
    output logic             scalingRegWrite,
    input  wire logic [7:0]  scalingRegRdata,
    input  wire logic        scalingRegDefined,
    output logic [7:0]       addressRemap,
    output logic             primaryHsMode,
    output logic             scalingHsMode
);
    // Edge detection needs several clocks per high-speed half bit.
    localparam int HALF_CYCLES = CLK_KHZ / (2 * `PMS_HS_RATE_KBPS);

    if (HALF_CYCLES < `PMS_MIN_HALF_CYCLES) begin : g_rate_check
        $error("Clock too slow for high-speed bus operation.");
    end

    pms_pkg::pms_top_t st;
    pms_pkg::pms_top_t next_st;

    logic [1:0] sclF;
    logic [1:0] sdaF;
    logic [1:0] sclPins;
    logic [1:0] sdaPins;
    logic [1:0] sclRise;
    logic [1:0] sclFall;
    logic [1:0] startEv;
    logic [1:0] stopEv;
    logic [1:0] regDefined;
    logic [7:0] rdVal    [2];
    logic [7:0] extRdata [2];
    logic [1:0] addrHit;
    logic [2:0] addrPage [2];

    assign sclPins    = {scalingClockPin, primaryClockPin};
    assign sdaPins    = {scalingDataPin, primaryDataPin};
    assign extRdata[0] = primaryRegRdata;
    assign extRdata[1] = scalingRegRdata;
    assign regDefined = {scalingRegDefined, primaryRegDefined};

    // ======================================================================
    // Per-port pin conditioning and bus events
    // ======================================================================
    pms_line_if line [2] ();

    for (genvar g = 0; g < 2; g++) begin : g_port
        pms_pin_sync u_sync (
            .clk    (clk),
            .srst   (srst),
            .ce     (ce),
            .sclPin (sclPins[g]),
            .sdaPin (sdaPins[g]),
            .line   (line[g])
        );

        assign sclF[g]    = line[g].scl;
        assign sdaF[g]    = line[g].sda;
        assign sclRise[g] = ce & sclF[g] & ~st.port[g].sclPrev;
        assign sclFall[g] = ce & ~sclF[g] & st.port[g].sclPrev;
        assign startEv[g] = ce & sclF[g] & st.port[g].sclPrev
                          & st.port[g].sdaPrev & ~sdaF[g];
        assign stopEv[g]  = ce & sclF[g] & st.port[g].sclPrev
                          & ~st.port[g].sdaPrev & sdaF[g];
    end

    // ======================================================================
    // Address decode
    // ======================================================================
    // Both ports decode from their own shift register, the general port also from
    // the remap register it alone writes, so an access on one never alters the other.
    always_comb begin
        logic [6:0] a0;
        logic [6:0] a1;
        logic       sel;
        a0  = st.port[0].shift[7:1];
        a1  = st.port[1].shift[7:1];
        sel = st.remap[a0[1:0]];
        addrHit[0] = (a0[6:2] == `PMS_GEN_BASE_DEF && !sel)
                   || (a0[6:2] == `PMS_GEN_BASE_ALT && sel);
        addrPage[0] = {1'b0, a0[1:0]};
        addrHit[1]  = (a1 == `PMS_SCALING_ADDR);
        addrPage[1] = `PMS_PAGE_SCALING;
    end

    // ======================================================================
    // Read data selection
    // ======================================================================
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            rdVal[p] = regDefined[p] ? extRdata[p] : `PMS_UNDEF_VALUE;
        end
        if (st.port[0].page == `PMS_PAGE_IFACE) begin
            if (st.port[0].idx == `PMS_REMAP_IDX) begin
                rdVal[0] = st.remap;
            end else if (st.port[0].idx == `PMS_STATUS_IDX) begin
                rdVal[0] = {6'h00, st.port[1].hsMode, st.port[0].hsMode};
            end
        end
    end

    // ======================================================================
    // Serial engines
    // ======================================================================
    always_comb begin
        next_st = st;
        for (int p = 0; p < 2; p++) begin
            next_st.port[p].sclPrev = sclF[p];
            next_st.port[p].sdaPrev = sdaF[p];
            next_st.port[p].wrPulse = 1'b0;
            if (st.port[p].wrPulse) begin
                next_st.port[p].idx = st.port[p].idx + 8'h01;
            end
            if (startEv[p]) begin
                // A repeated start keeps the index and the high-speed mode.
                next_st.port[p].state     = pms_pkg::PMS_ADDR;
                next_st.port[p].bitCnt    = 4'h0;
                next_st.port[p].drvLow    = 1'b0;
                next_st.port[p].idxLoaded = 1'b0;
            end else if (stopEv[p]) begin
                next_st.port[p].state  = pms_pkg::PMS_IDLE;
                next_st.port[p].drvLow = 1'b0;
                next_st.port[p].hsMode = 1'b0;
            end else if (sclRise[p]) begin
                case (st.port[p].state)
                    pms_pkg::PMS_ADDR, pms_pkg::PMS_WR: begin
                        next_st.port[p].shift =
                            {st.port[p].shift[6:0], sdaF[p]};
                        next_st.port[p].bitCnt =
                            st.port[p].bitCnt + 4'h1;
                    end
                    pms_pkg::PMS_RD: begin
                        next_st.port[p].bitCnt =
                            st.port[p].bitCnt + 4'h1;
                    end
                    pms_pkg::PMS_RD_ACK: begin
                        next_st.port[p].nack = sdaF[p];
                    end
                    default: begin
                    end
                endcase
            end else if (sclFall[p]) begin
                case (st.port[p].state)
                    pms_pkg::PMS_ADDR: begin
                        if (st.port[p].bitCnt == `PMS_BYTE_BITS) begin
                            next_st.port[p].rw = st.port[p].shift[0];
                            if (st.port[p].shift[7:3] ==
                                `PMS_HS_CODE_TOP) begin
                                // Master code: switch, stay silent.
                                next_st.port[p].hsMode = 1'b1;
                                next_st.port[p].state  = pms_pkg::PMS_IDLE;
                            end else if (addrHit[p]) begin
                                next_st.port[p].drvLow = 1'b1;
                                next_st.port[p].page   = addrPage[p];
                                next_st.port[p].state  =
                                    pms_pkg::PMS_ADDR_ACK;
                            end else begin
                                next_st.port[p].state =
                                    pms_pkg::PMS_IDLE;
                            end
                        end
                    end
                    pms_pkg::PMS_ADDR_ACK, pms_pkg::PMS_RD_ACK: begin
                        next_st.port[p].bitCnt = 4'h0;
                        if (st.port[p].state == pms_pkg::PMS_RD_ACK &&
                            st.port[p].nack) begin
                            next_st.port[p].drvLow = 1'b0;
                            next_st.port[p].state  = pms_pkg::PMS_IDLE;
                        end else if (st.port[p].rw) begin
                            next_st.port[p].drvLow = ~rdVal[p][7];
                            next_st.port[p].tx     = {rdVal[p][6:0], 1'b0};
                            next_st.port[p].state  = pms_pkg::PMS_RD;
                        end else begin
                            next_st.port[p].drvLow = 1'b0;
                            next_st.port[p].state  = pms_pkg::PMS_WR;
                        end
                    end
                    pms_pkg::PMS_WR: begin
                        if (st.port[p].bitCnt == `PMS_BYTE_BITS) begin
                            next_st.port[p].drvLow = 1'b1;
                            next_st.port[p].state  = pms_pkg::PMS_WR_ACK;
                            if (!st.port[p].idxLoaded) begin
                                next_st.port[p].idx = st.port[p].shift;
                                next_st.port[p].idxLoaded = 1'b1;
                            end else if (p == 0 &&
                                st.port[0].page == `PMS_PAGE_IFACE &&
                                st.port[0].idx == `PMS_REMAP_IDX) begin
                                // Lower four bits steer the page decode.
                                next_st.remap = st.port[0].shift;
                                next_st.port[p].idx = st.port[p].idx + 8'h01;
                            end else begin
                                next_st.port[p].wrPulse = 1'b1;
                                next_st.port[p].wdata   = st.port[p].shift;
                            end
                        end
                    end
                    pms_pkg::PMS_WR_ACK: begin
                        next_st.port[p].drvLow = 1'b0;
                        next_st.port[p].bitCnt = 4'h0;
                        next_st.port[p].state  = pms_pkg::PMS_WR;
                    end
                    pms_pkg::PMS_RD: begin
                        if (st.port[p].bitCnt == `PMS_BYTE_BITS) begin
                            // Release so the master can acknowledge.
                            next_st.port[p].drvLow = 1'b0;
                            next_st.port[p].nack   = 1'b1;
                            next_st.port[p].idx = st.port[p].idx + 8'h01;
                            next_st.port[p].state  = pms_pkg::PMS_RD_ACK;
                        end else begin
                            next_st.port[p].drvLow = ~st.port[p].tx[7];
                            next_st.port[p].tx = {st.port[p].tx[6:0], 1'b0};
                        end
                    end
                    default: begin
                        next_st.port[p].state = pms_pkg::PMS_IDLE;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st       <= '0;
            st.remap <= `PMS_REMAP_RESET;
            st.port[0].sclPrev <= 1'b1;
            st.port[0].sdaPrev <= 1'b1;
            st.port[1].sclPrev <= 1'b1;
            st.port[1].sdaPrev <= 1'b1;
        end else if (ce) begin
            st <= next_st;
        end
    end

    // ======================================================================
    // Outputs
    // ======================================================================
    // Open drain: the data line is only ever pulled low, never the clock.
    assign primaryDataOut  = 1'b0;
    assign scalingDataOut  = 1'b0;
    assign primaryDataOeN  = ~st.port[0].drvLow;
    assign scalingDataOeN  = ~st.port[1].drvLow;
    assign primaryRegPage  = st.port[0].page;
    assign primaryRegIndex = st.port[0].idx;
    assign primaryRegWdata = st.port[0].wdata;
    assign primaryRegWrite = st.port[0].wrPulse;
    assign scalingRegPage  = st.port[1].page;
    assign scalingRegIndex = st.port[1].idx;
    assign scalingRegWdata = st.port[1].wdata;
    assign scalingRegWrite = st.port[1].wrPulse;
    assign addressRemap    = st.remap;
    assign primaryHsMode   = st.port[0].hsMode;
    assign scalingHsMode   = st.port[1].hsMode;

    // ======================================================================
    // Checks
    // ======================================================================
    for (genvar g = 0; g < 2; g++) begin : g_chk
        AST_START_ADDR: assert property (@(posedge clk) disable iff (srst)
            startEv[g] |=> st.port[g].state == pms_pkg::PMS_ADDR
                && st.port[g].bitCnt == 4'h0 && !st.port[g].drvLow)
            else $error("Start did not open an address byte.");

        AST_STOP_RELEASE: assert property (@(posedge clk)
            disable iff (srst)
            stopEv[g] |=> st.port[g].state == pms_pkg::PMS_IDLE
                && !st.port[g].drvLow && !st.port[g].hsMode)
            else $error("Stop did not release the bus.");

        AST_HS_NO_ACK: assert property (@(posedge clk) disable iff (srst)
            sclFall[g] && st.port[g].state == pms_pkg::PMS_ADDR
                && st.port[g].bitCnt == `PMS_BYTE_BITS
                && st.port[g].shift[7:3] == `PMS_HS_CODE_TOP
            |=> st.port[g].hsMode && !st.port[g].drvLow [*2])
            else $error("Master code was acknowledged.");

        AST_HS_HOLD: assert property (@(posedge clk) disable iff (srst)
            st.port[g].hsMode && !stopEv[g] |=> st.port[g].hsMode)
            else $error("High-speed mode dropped without a stop.");

        AST_NO_GENCALL: assert property (@(posedge clk)
            disable iff (srst)
            sclFall[g] && st.port[g].state == pms_pkg::PMS_ADDR
                && st.port[g].bitCnt == `PMS_BYTE_BITS
                && st.port[g].shift[7:1] == `PMS_GENERAL_CALL
            |=> st.port[g].state == pms_pkg::PMS_IDLE)
            else $error("General call was answered.");

        AST_ACK_ONLY_MATCH: assert property (@(posedge clk)
            disable iff (srst)
            $rose(st.port[g].state == pms_pkg::PMS_ADDR_ACK)
            |-> $past(addrHit[g]) && st.port[g].drvLow)
            else $error("Address acknowledged without a match.");

        AST_WR_INCR: assert property (@(posedge clk) disable iff (srst)
            st.port[g].wrPulse && ce
            |=> st.port[g].idx == $past(st.port[g].idx) + 8'h01)
            else $error("Index did not advance after a write.");

        AST_UNDEF_FF: assert property (@(posedge clk) disable iff (srst)
            sclFall[g] && st.port[g].state == pms_pkg::PMS_ADDR_ACK
                && st.port[g].rw && !regDefined[g]
                && !(g == 0 && st.port[0].page == `PMS_PAGE_IFACE)
            |=> st.port[g].drvLow == 1'b0 && st.port[g].tx == 8'hfe)
            else $error("Undefined register did not read as 0xFF.");
    end

    AST_SCALING_PAGE: assert property (@(posedge clk) disable iff (srst)
        scalingRegWrite |-> scalingRegPage == `PMS_PAGE_SCALING)
        else $error("Scaling port left its page.");

    AST_SCALING_FIXED: assert property (@(posedge clk) disable iff (srst)
        sclFall[1] && st.port[1].state == pms_pkg::PMS_ADDR
            && st.port[1].bitCnt == `PMS_BYTE_BITS
            && st.port[1].shift[7:1] == `PMS_SCALING_ADDR
        |=> st.port[1].state == pms_pkg::PMS_ADDR_ACK && st.port[1].drvLow)
        else $error("Scaling port missed its fixed address.");

endmodule : pms_dual_slave

// ### test/pms_master.sv
// Behavioural bus master for one serial port of the register slave.
// Assumes a pull-up on the data wire; the master drives the clock and only pulls data low.
`timescale 1ns/1ps
module pms_master (
    output logic      scl,
    output logic      sdaRel,
    input  wire logic sda
);
    localparam realtime H = 62.5;
    initial begin
        scl = 1'b1;
        sdaRel = 1'b1;
    end
    // =====================================================================
    // Conditions and bytes
    // =====================================================================
    task startC;
        #(H / 2) sdaRel = 1'b1;
        #H scl = 1'b1;
        #H sdaRel = 1'b0;
        #H scl = 1'b0;
    endtask : startC
    task stopC;
        #(H / 2) sdaRel = 1'b0;
        #H scl = 1'b1;
        #H sdaRel = 1'b1;
        #H;
    endtask : stopC
    // Data moves half way through the low phase, clear of both clock edges,
    // so the slave never sees it change while the clock is high.
    task byteX(input logic [8:0] o, output logic [8:0] i);
        for (int k = 8; k >= 0; k--) begin
            #(H / 2) sdaRel = o[k];
            #(H / 2) scl = 1'b1;
            #(H / 2) i[k] = sda;
            #(H / 2) scl = 1'b0;
        end
    endtask : byteX
endmodule : pms_master

// ### test/testbench.sv
// Self-checking bench: two masters drive the ports, a table answers reads.
// Assumes the slave and the master model are compiled first.
`timescale 1ns/1ps
module testbench;
    logic clk = 0, srst = 1, ce = 1, pScl, pRel, sScl, sRel, pOeN, sOeN;
    logic pWr, sWr, pHs, sHs, pDo, sDo;
    logic [6:0] na [4] = '{7'h12, 7'h00, 7'h58, 7'h78};
    logic [2:0] pPg, sPg, wPg, g;
    logic [7:0] pIx, sIx, pWd, sWd, remap, wIx, wd, x, d;
    logic [8:0] rx [2];
    int fail_count = 0, comparisons = 0, seed = 14, sWn = 0;
    wire pSda = pRel & pOeN;
    wire sSda = sRel & sOeN;
    always #5 clk = ~clk;
    pms_master pms_master_inst (.scl(pScl), .sdaRel(pRel), .sda(pSda));
    pms_master scaling_master (.scl(sScl), .sdaRel(sRel), .sda(sSda));
    function logic [7:0] rv(input logic [2:0] p, input logic [7:0] i);
        return i[7] ? 8'hff : i ^ {p, 5'h15};
    endfunction : rv
    pms_dual_slave pms_dual_slave_inst (.clk(clk), .srst(srst), .ce(ce),
        .primaryClockPin(pScl), .primaryDataPin(pSda), .primaryDataOut(pDo),
        .primaryDataOeN(pOeN), .scalingClockPin(sScl),
        .scalingDataPin(sSda), .scalingDataOut(sDo), .scalingDataOeN(sOeN),
        .primaryRegPage(pPg), .primaryRegIndex(pIx), .primaryRegWdata(pWd),
        .primaryRegWrite(pWr), .primaryRegRdata(rv(pPg, pIx)),
        .primaryRegDefined(~pIx[7]), .scalingRegPage(sPg),
        .scalingRegIndex(sIx), .scalingRegWdata(sWd), .scalingRegWrite(sWr),
        .scalingRegRdata(rv(sPg, sIx)), .scalingRegDefined(~sIx[7]),
        .addressRemap(remap), .primaryHsMode(pHs), .scalingHsMode(sHs));
    always @(posedge clk) if (pWr) {wPg, wIx, wd} <= {pPg, pIx, pWd};
    always @(posedge clk) if (sWr) sWn <= sWn + 1;
    // =====================================================================
    // Helpers
    // =====================================================================
    task check(input string n, input logic [23:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic xb(input logic s, input logic [7:0] v, input logic n);
        if (s) scaling_master.byteX({v, n}, rx[1]);
        else pms_master_inst.byteX({v, n}, rx[0]);
    endtask : xb
    task automatic st(input logic s, input logic [6:0] a, input logic r);
        if (s) scaling_master.startC();
        else pms_master_inst.startC();
        xb(s, {a, r}, 1'b1);
    endtask : st
    task automatic sp(input logic s);
        if (s) scaling_master.stopC();
        else pms_master_inst.stopC();
    endtask : sp
    task automatic ack(input logic s, input logic [6:0] a, input logic e);
        st(s, a, 1'b0);
        check("ack", rx[s][0], e);
        sp(s);
    endtask : ack
    task test_done;
        if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : test_done
    initial begin
        #500000 fail_count++;
        test_done();
    end
    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        repeat (12) @(posedge clk);
        @(negedge clk) srst = 1'b0;
        repeat (6) @(posedge clk);
        check("remapRst", remap, 8'h00);
        check("outRst", {pHs, sHs, pDo, sDo, pOeN, sOeN}, 6'h03);
        for (int k = 0; k < 9; k++) begin
            g = (k == 8) ? 3'h0 : 3'($random(seed) & 3);
            x = (k == 8) ? 8'h8f : 8'($random(seed)) & 8'h7f;
            d = $random(seed);
            st(0, {5'h12, g[1:0]}, 0);
            xb(0, x, 1);
            xb(0, d, 1);
            check("wrAck", rx[0][0], 0);
            check("wr", {wPg, wIx, wd}, {g, x, d});
            st(0, {5'h12, g[1:0]}, 1);
            xb(0, 8'hff, 1);
            check("rd", rx[0][8:1], rv(g, x + 8'h1));
            sp(0);
        end
        foreach (na[i]) ack(0, na[i], 1);
        ack(1, 7'h48, 1);
        fork
            begin
                st(0, 7'h49, 0);
                xb(0, 8'hf0, 1);
                xb(0, 8'h01, 1);
                sp(0);
            end
            begin
                st(1, 7'h12, 0);
                xb(1, 8'h20, 1);
                xb(1, 8'h5a, 1);
                check("sPg", {sPg, sIx, sWd}, {3'h4, 8'h21, 8'h5a});
                sp(1);
            end
        join
        check("remap", remap, 8'h01);
        check("sWn", sWn, 1);
        ack(0, 7'h48, 1);
        ack(0, 7'h58, 0);
        ack(1, 7'h12, 0);
        st(0, 7'h04, 0);
        check("hsNack", {rx[0][0], pHs}, 2'b11);
        st(0, 7'h49, 0);
        check("hsKeep", {rx[0][0], pHs}, 2'b01);
        sp(0);
        #100 check("hsEnd", pHs, 0);
        test_done();
    end
endmodule : testbench
